//--- hdl/otp_sec_pkg.sv
// Package: constants and types for the tile OTP and security control block
package otp_sec_pkg;

    // Array geometry: four sectors of 512 rows, 32 bits a row (8 KB)
    localparam int unsigned ROW_BITS = 32;
    localparam int unsigned SECTOR_COUNT = 4;
    localparam int unsigned ROWS_PER_SECTOR = 512;
    localparam int unsigned ROW_COUNT = SECTOR_COUNT * ROWS_PER_SECTOR;
    localparam int unsigned ROW_ADDR_BITS = 11;

    // Resource identifiers of the three programming ports
    localparam logic [23:0] RES_OTP_ADDR = 24'h100200;
    localparam logic [23:0] RES_OTP_DATA = 24'h200100;
    localparam logic [23:0] RES_OTP_CTRL = 24'h100300;

    // Register bus offsets (byte addresses)
    localparam logic [7:0] OFS_SECURITY = 8'h00;
    localparam logic [7:0] OFS_OTP_ADDR = 8'h04;
    localparam logic [7:0] OFS_OTP_DATA = 8'h08;
    localparam logic [7:0] OFS_OTP_CTRL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_READ_DATA = 8'h14;

    // Security bit positions
    localparam int unsigned SEC_DEBUG_OFF = 0;
    localparam int unsigned SEC_SWITCH_OFF = 1;
    localparam int unsigned SEC_OTP_BOOT = 5;
    localparam int unsigned SEC_REDUNDANT = 7;
    localparam int unsigned SEC_SECTOR_LOCK_LO = 8;
    localparam int unsigned SEC_MASTER_LOCK = 12;
    localparam int unsigned SEC_DEBUG_OTP_OFF = 13;
    localparam int unsigned SEC_USER_LO = 15;
    localparam int unsigned SEC_USER_HI = 21;
    localparam int unsigned SEC_UID_LO = 22;
    localparam int unsigned SEC_UID_HI = 31;

    // Security row is the last row of the array
    localparam logic [10:0] SEC_ROW = 11'h7FF;
    // Writable bits of the security register from software (general purpose field)
    localparam logic [31:0] SEC_SW_MASK = 32'h003F8000;

    // Control port commands
    localparam logic [15:0] CMD_PROGRAM = 16'h0001;
    localparam logic [15:0] CMD_READ = 16'h0002;
    localparam logic [15:0] CMD_PROGRAM_SEC = 16'h0003;

    // Status bits
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_LOADED = 1;
    localparam int unsigned ST_REFUSED = 2;

    // Program pulse time in ns and derived cycle count at 40 MHz
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned PROG_TIME_NS = 1000;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] PROG_CYCLES_W = 16'(PROG_CYCLES);

    // Identity of the silicon revision in the user code (arbitrary value)
    localparam logic [21:0] USERCODE_LOW = 22'h000000;

    // Register port bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Debug port / switch request bundle
    typedef struct packed {
        logic valid;
        logic is_otp;
        logic write;
    } access_req_t;

endpackage // otp_sec_pkg

//--- hdl/otp_security_control.sv
// Tile OTP controller with security configuration register
//
// The plain strobed port and the placing of the registers were decided locally.
module otp_security_control
    import otp_sec_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Register port
    input wire reg_req_t i_reg,
    output logic [31:0] o_rdata,
    // Access requests to be filtered
    input wire access_req_t i_debug_req,
    input wire access_req_t i_switch_req,
    output logic o_debug_grant,
    output logic o_switch_grant,
    // Boot and copy-out to SRAM
    output logic o_boot_ready,
    output logic o_boot_from_otp,
    output logic o_copy_valid,
    output logic [ROW_ADDR_BITS-1:0] o_copy_addr,
    output logic [31:0] o_copy_data,
    output logic o_copy_done,
    // Redundant row enable and debug user code
    output logic o_redundant_rows,
    output logic [31:0] o_usercode
);

    // Controller states
    typedef enum logic [2:0] {
        ST_LOAD_SEC, // Read the security row
        ST_COPY, // Stream rows out to SRAM
        ST_IDLE, // Wait for a command
        ST_PROG, // Program pulse running
        ST_READ // Fetch one row
    } state_t;

    state_t state;
    logic [ROW_BITS-1:0] otp_mem [ROW_COUNT];
    logic [31:0] security;
    logic [15:0] otp_addr;
    logic [31:0] otp_data;
    logic [31:0] read_data;
    logic [15:0] prog_count;
    logic [ROW_ADDR_BITS-1:0] copy_ptr;
    logic refused;
    logic loaded;
    logic cmd_prog;
    logic cmd_prog_sec;
    logic cmd_read;
    logic prog_locked;
    logic sec_locked;
    logic [1:0] target_sector;
    logic prog_is_sec;

    // Helper terms shared by several processes
    logic [SECTOR_COUNT-1:0] sector_lock;
    logic prog_start;
    logic prog_refused;
    logic prog_done;
    logic busy;
    logic copy_last;
    logic sec_sw_write;
    logic [31:0] next_security;
    logic [31:0] status_word;
    logic debug_blocked;
    logic debug_otp_blocked;

    // Flow after reset: one cycle loads the security word from its row,
    // then one row a cycle streams out to SRAM, then commands are served.
    // Commands written while loading, copying or programming are dropped,
    // but the busy bit of the status word is set only while programming, not during load or copy.
    // Bits loaded from the security row take effect only after the load cycle;
    // until then every grant stays low.

    // Command decode on the control port; a command is a write of its code
    assign cmd_prog = i_reg.wr && i_reg.addr == OFS_OTP_CTRL
        && i_reg.wdata[15:0] == CMD_PROGRAM;
    assign cmd_prog_sec = i_reg.wr && i_reg.addr == OFS_OTP_CTRL
        && i_reg.wdata[15:0] == CMD_PROGRAM_SEC;
    assign cmd_read = i_reg.wr && i_reg.addr == OFS_OTP_CTRL
        && i_reg.wdata[15:0] == CMD_READ;
    // Sector of the addressed row: the top two row address bits
    assign target_sector = otp_addr[ROW_ADDR_BITS-1 -: 2];

    // Per-sector program lock, one entry per sector
    genvar gs;
    generate
        for (gs = 0; gs < SECTOR_COUNT; gs++) begin : g_sector_lock
            // A sector closes on its own lock bit or on the master lock
            assign sector_lock[gs] = security[SEC_SECTOR_LOCK_LO + gs]
                || security[SEC_MASTER_LOCK];
        end
    endgenerate

    // Lock check for a data row and for the security row
    assign prog_locked = sector_lock[target_sector];
    assign sec_locked = security[SEC_MASTER_LOCK];
    // Program request, and whether the locks turn it away
    assign prog_start = cmd_prog || cmd_prog_sec;
    assign prog_refused = (cmd_prog && prog_locked) || (cmd_prog_sec && sec_locked);
    // Pulse timing and end of the copy-out
    assign busy = state == ST_PROG;
    assign prog_done = busy && prog_count <= 16'h0001; // Last pulse cycle: cells take the data
    assign copy_last = state == ST_COPY && copy_ptr == SEC_ROW - 11'h001;
    // Software write to the general purpose field of the security register
    assign sec_sw_write = i_reg.wr && i_reg.addr == OFS_SECURITY;

    // Controller sequence: load security, copy out, then serve commands
    // A refused command leaves the array alone and raises the refused flag
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_LOAD_SEC;
            copy_ptr <= '0;
            prog_count <= '0;
            refused <= 1'b0;
            loaded <= 1'b0;
            prog_is_sec <= 1'b0;
        end else begin
            case (state)
                ST_LOAD_SEC: begin
                    loaded <= 1'b1;
                    state <= ST_COPY;
                end
                ST_COPY: begin
                    if (copy_last) begin
                        state <= ST_IDLE;
                    end else begin
                        copy_ptr <= copy_ptr + 11'h001;
                    end
                end
                ST_IDLE: begin
                    if (prog_start) begin
                        if (prog_refused) begin
                            refused <= 1'b1;
                        end else begin
                            refused <= 1'b0;
                            prog_is_sec <= cmd_prog_sec;
                            prog_count <= PROG_CYCLES_W;
                            state <= ST_PROG;
                        end
                    end else if (cmd_read) begin
                        state <= ST_READ;
                    end
                end
                ST_PROG: begin
                    if (prog_count <= 16'h0001) begin
                        state <= ST_IDLE;
                    end else begin
                        prog_count <= prog_count - 16'h0001;
                    end
                end
                ST_READ: begin
                    state <= ST_IDLE; // One cycle to fetch the row
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // OTP array: bits only ever get set, never cleared
    // No reset here: the cells are non-volatile and keep their contents over reset
    always_ff @(posedge i_clk_sys) begin
        if (prog_done) begin
            if (prog_is_sec) begin
                otp_mem[SEC_ROW] <= otp_mem[SEC_ROW] | otp_data;
            end else begin
                otp_mem[otp_addr[ROW_ADDR_BITS-1:0]] <=
                    otp_mem[otp_addr[ROW_ADDR_BITS-1:0]] | otp_data;
            end
        end
    end

    // Next security value: a program pulse and a software write may meet,
    // and the bits of both are kept
    always_comb begin
        next_security = security;
        if (prog_done && prog_is_sec) begin
            next_security = next_security | otp_data;
        end
        if (sec_sw_write) begin
            next_security = next_security | (i_reg.wdata & SEC_SW_MASK);
        end
    end

    // Security register: loaded from OTP at start, then only ever gains bits
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            security <= 32'h00000000;
        end else if (state == ST_LOAD_SEC) begin
            security <= otp_mem[SEC_ROW];
        end else begin
            security <= next_security;
        end
    end

    // Address and data ports of the programming interface
    // Both stay frozen during a pulse, so the cells always see one word
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            otp_addr <= 16'h0000;
            otp_data <= 32'h00000000;
        end else if (state != ST_PROG && i_reg.wr) begin
            if (i_reg.addr == OFS_OTP_ADDR) begin
                otp_addr <= i_reg.wdata[15:0];
            end
            if (i_reg.addr == OFS_OTP_DATA) begin
                otp_data <= i_reg.wdata;
            end
        end
    end

    // OTP read-back for the read command
    // The result holds until the next read command
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            read_data <= 32'h00000000;
        end else if (state == ST_READ) begin
            read_data <= otp_mem[otp_addr[ROW_ADDR_BITS-1:0]];
        end
    end

    // Copy-out stream to SRAM, one row per cycle
    // The last row holds the security word and is never copied out
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_copy_valid <= 1'b0;
            o_copy_addr <= '0;
            o_copy_data <= 32'h00000000;
            o_copy_done <= 1'b0;
        end else begin
            o_copy_valid <= state == ST_COPY;
            o_copy_addr <= copy_ptr;
            o_copy_data <= otp_mem[copy_ptr];
            o_copy_done <= o_copy_done || copy_last;
        end
    end

    // Read data, one cycle after the read strobe
    // Zero outside the answer cycle, so a stale word never shows on the bus
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h00000000;
        end else if (i_reg.rd) begin
            case (i_reg.addr)
                OFS_SECURITY: o_rdata <= security;
                OFS_OTP_ADDR: o_rdata <= {16'h0000, otp_addr};
                OFS_OTP_DATA: o_rdata <= otp_data;
                OFS_OTP_CTRL: o_rdata <= 32'h00000000;
                OFS_STATUS: o_rdata <= status_word;
                OFS_READ_DATA: o_rdata <= read_data;
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // Status word: refused, loaded and busy from the top down
    assign status_word = {29'h0, refused, loaded, busy};

    // Debug blocking terms: the whole tile, or only the OTP behind it
    assign debug_blocked = security[SEC_DEBUG_OFF];
    assign debug_otp_blocked = i_debug_req.is_otp && security[SEC_DEBUG_OTP_OFF];

    // Access gating from the security bits; nothing granted until loaded
    // Grants are combinational, so a request is filtered in the cycle it arrives
    assign o_debug_grant = loaded && i_debug_req.valid && !debug_blocked && !debug_otp_blocked;
    assign o_switch_grant = loaded && i_switch_req.valid && !security[SEC_SWITCH_OFF];

    // Boot path selection
    assign o_boot_ready = o_copy_done;
    assign o_boot_from_otp = security[SEC_OTP_BOOT];
    assign o_redundant_rows = security[SEC_REDUNDANT];
    // User code: OTP user ID on top, fixed revision field below
    assign o_usercode = {security[SEC_UID_HI:SEC_UID_LO], USERCODE_LOW};

endmodule // otp_security_control

//--- dv/otp_sec_checker_asserts.sv
// Port-level assertions for the OTP security control block
module otp_sec_checker
    import otp_sec_pkg::*;
(
    // Clock, reset, register port
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire reg_req_t i_reg,
    input wire logic [31:0] o_rdata,
    // Access filter
    input wire access_req_t i_debug_req,
    input wire access_req_t i_switch_req,
    input wire logic o_debug_grant,
    input wire logic o_switch_grant,
    // Boot, copy-out, status outputs
    input wire logic o_boot_ready,
    input wire logic o_boot_from_otp,
    input wire logic o_copy_valid,
    input wire logic [ROW_ADDR_BITS-1:0] o_copy_addr,
    input wire logic o_copy_done,
    input wire logic o_redundant_rows,
    input wire logic [31:0] o_usercode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    // Two rows copied in consecutive cycles
    sequence two_copies;
        o_copy_valid ##1 o_copy_valid;
    endsequence

    rdata_idle_a: assert property (!$past(i_reg.rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside read slot");
    dbg_grant_a: assert property (o_debug_grant |-> i_debug_req.valid)
        else $error("debug grant without request");
    sw_grant_a: assert property (o_switch_grant |-> i_switch_req.valid)
        else $error("switch grant without request");
    uid_low_a: assert property (o_usercode[21:0] == 22'h0)
        else $error("user code low field not zero");
    uid_stick_a: assert property (($past(o_usercode) & ~o_usercode) == 32'h0)
        else $error("user code bit returned to zero");
    boot_fixed_a: assert property (o_copy_done |-> !$rose(o_boot_from_otp))
        else $error("boot source changed after load");
    copy_step_a: assert property (two_copies |-> o_copy_addr == $past(o_copy_addr) + 11'h1)
        else $error("copy address did not step by one");
    copy_row_a: assert property (o_copy_valid |-> o_copy_addr != SEC_ROW)
        else $error("security row copied to memory");
    done_stick_a: assert property (o_copy_done |=> o_copy_done && o_boot_ready)
        else $error("copy done dropped or boot ready missing");
    redund_hold_a: assert property (o_copy_done |-> $stable(o_redundant_rows))
        else $error("redundant row enable changed after load");
endmodule // otp_sec_checker

bind otp_security_control otp_sec_checker u_otp_sec_checker (.*);

//--- dv/sram_sink.sv
// Memory model that receives the rows copied out at boot
module sram_sink
    import otp_sec_pkg::*;
(
    // Clock and copy stream
    input wire logic i_clk_sys,
    input wire logic i_copy_valid,
    input wire logic [ROW_ADDR_BITS-1:0] i_copy_addr,
    input wire logic [31:0] i_copy_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:ROW_COUNT-1];
    int rows = 0;

    // Store each copied row and count them
    always @(posedge i_clk_sys) begin
        if (i_copy_valid === 1'b1) begin
            mem[i_copy_addr] <= i_copy_data;
            rows <= rows + 1;
        end
    end
endmodule // sram_sink

//--- dv/otp_security_control_test.sv
// Self-checking testbench for the OTP security control block
module otp_security_control_test
    import otp_sec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys, i_resetn, o_debug_grant, o_switch_grant, o_boot_ready, o_boot_from_otp;
    logic o_copy_valid, o_copy_done, o_redundant_rows;
    logic [31:0] o_rdata, o_copy_data, o_usercode;
    logic [ROW_ADDR_BITS-1:0] o_copy_addr;
    reg_req_t i_reg;
    access_req_t i_debug_req, i_switch_req;
    int num_errors = 0;
    int n_compared = 0;
    localparam logic [31:0] SEC = 32'hA94022A3;

    otp_security_control u_otp_security_control (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_reg(i_reg), .o_rdata(o_rdata),
        .i_debug_req(i_debug_req), .i_switch_req(i_switch_req),
        .o_debug_grant(o_debug_grant), .o_switch_grant(o_switch_grant),
        .o_boot_ready(o_boot_ready), .o_boot_from_otp(o_boot_from_otp),
        .o_copy_valid(o_copy_valid), .o_copy_addr(o_copy_addr), .o_copy_data(o_copy_data),
        .o_copy_done(o_copy_done), .o_redundant_rows(o_redundant_rows),
        .o_usercode(o_usercode));
    sram_sink u_sram_sink (.i_clk_sys(i_clk_sys), .i_copy_valid(o_copy_valid),
        .i_copy_addr(o_copy_addr), .i_copy_data(o_copy_data));

    // Clock at 40 MHz
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Register bus write and read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys) i_reg <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk_sys) i_reg <= '{a, d, 1'b0, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk_sys) i_reg <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clk_sys) i_reg.rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask

    // Issue a row command and wait out the program time
    task automatic cmd(input logic [10:0] a, input logic [31:0] d, input logic [15:0] c);
        wr(OFS_OTP_ADDR, {21'h0, a});
        wr(OFS_OTP_DATA, d);
        wr(OFS_OTP_CTRL, {16'h0, c});
        repeat (PROG_CYCLES + 4) @(posedge i_clk_sys);
    endtask
    task automatic row(input logic [10:0] a, input logic [31:0] exp);
        cmd(a, 32'h0, CMD_READ);
        rd(OFS_READ_DATA, exp);
    endtask

    // Reset for 8 cycles and wait for the copy-out to end
    task automatic boot();
        int n;
        @(posedge i_clk_sys) i_resetn <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        for (n = 0; n < 3000 && o_copy_done !== 1'b1; n++) @(posedge i_clk_sys);
        #1 chk(o_copy_done, 1);
    endtask

    task automatic t_boot();
        boot();
        chk(u_sram_sink.rows, ROW_COUNT - 1);
        chk(o_boot_from_otp, 0);
        chk(o_usercode, 0);
        rd(OFS_SECURITY, 0);
        @(posedge i_clk_sys) i_debug_req <= '{1'b1, 1'b1, 1'b0};
        i_switch_req <= '{1'b1, 1'b0, 1'b0};
        @(posedge i_clk_sys) #1 chk({o_debug_grant, o_switch_grant}, 2'b11);
        $display("boot test done");
    endtask

    task automatic t_prog();
        cmd(11'h005, 32'h12345678, CMD_PROGRAM);
        cmd(11'h005, 32'h00000001, CMD_PROGRAM);
        row(11'h005, 32'h12345679);
        wr(OFS_SECURITY, 32'hFFFFFFFF);
        rd(OFS_SECURITY, SEC_SW_MASK);
        wr(OFS_SECURITY, 32'h0);
        rd(OFS_SECURITY, SEC_SW_MASK);
        rd(8'h20, 0);
        cmd(SEC_ROW, 32'h00002000, CMD_PROGRAM_SEC);
        rd(OFS_SECURITY, SEC_SW_MASK | 32'h00002000);
        chk(o_debug_grant, 0);
        @(posedge i_clk_sys) i_debug_req <= '{1'b1, 1'b0, 1'b0};
        @(posedge i_clk_sys) #1 chk(o_debug_grant, 1);
        @(posedge i_clk_sys) i_debug_req <= '{1'b1, 1'b1, 1'b0};
        $display("program test done");
    endtask

    task automatic t_secure();
        u_otp_security_control.otp_mem[SEC_ROW] = SEC;
        boot();
        chk(o_usercode, {SEC[31:22], 22'h0});
        chk({o_boot_from_otp, o_redundant_rows}, 2'b11);
        rd(OFS_SECURITY, SEC);
        chk({o_debug_grant, o_switch_grant}, 2'b00);
        chk(u_sram_sink.mem[5], 32'h12345679);
        cmd(11'h200, 32'hFFFFFFFF, CMD_PROGRAM);
        rd(OFS_STATUS, 32'h6);
        row(11'h200, 0);
        cmd(11'h005, 32'h00000100, CMD_PROGRAM);
        rd(OFS_STATUS, 32'h2);
        $display("secure test done");
    endtask

    task automatic t_master();
        cmd(SEC_ROW, 32'h00001000, CMD_PROGRAM_SEC);
        boot();
        rd(OFS_SECURITY, SEC | 32'h1000);
        cmd(11'h005, 32'hFFFF0000, CMD_PROGRAM);
        rd(OFS_STATUS, 32'h6);
        row(11'h005, 32'h12345779);
        $display("master lock test done");
    endtask

    // Verdict and end of run
    task automatic results();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence with unprogrammed array preloaded to zero
    initial begin
        i_resetn = 1'b0;
        i_reg = '0;
        i_debug_req = '0;
        i_switch_req = '0;
        for (int i = 0; i < ROW_COUNT; i++) u_otp_security_control.otp_mem[i] = 32'h0;
        t_boot();
        t_prog();
        t_secure();
        t_master();
        results();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        num_errors++;
        results();
    end
endmodule // otp_security_control_test
